// *** rtl/fpep_pkg.sv ***
package fpep_pkg;

	// register indices on the plain register port
	localparam logic [1:0] FPEP_OFS_CTRL1 = 2'h0;
	localparam logic [1:0] FPEP_OFS_CTRL2 = 2'h1;
	localparam logic [1:0] FPEP_OFS_BLKSEL = 2'h2;

	// flash_control_one field positions
	localparam int FPEP_C1_PROG = 0;
	localparam int FPEP_C1_ERASE = 1;
	localparam int FPEP_C1_PV = 2;
	localparam int FPEP_C1_EV = 3;
	localparam int FPEP_C1_SWE = 6;

	// flash_control_two field positions
	localparam int FPEP_C2_PSU = 0;
	localparam int FPEP_C2_ESU = 1;
	localparam int FPEP_C2_FLASH_ERROR_FLAG = 7;

	// reset values
	localparam logic [7:0] FPEP_CTRL_RST = 8'h00;
	localparam logic [7:0] FPEP_BLK_RST = 8'h00;

	// hardware reset minimum hold at the pin, system cycles
	localparam int FPEP_RST_HOLD_CYC = 10;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fpep_req_t;

	typedef struct packed {
		logic prog;
		logic erase;
		logic pverify;
		logic everify;
	} fpep_mode_t;

	typedef enum logic [3:0] {
		FPEP_ST_PROT = 4'b0001,
		FPEP_ST_OPEN = 4'b0010,
		FPEP_ST_ERR  = 4'b0100,
		FPEP_ST_HOLD = 4'b1000
	} fpep_state_t;

endpackage

// *** rtl/fpep_protect.sv ***
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module fpep_protect
	import fpep_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       flash_write_enable_pin,
	input  wire logic       standby,
	input  wire logic       flash_read,
	input  wire logic       exception_start,
	input  wire logic       sleep_exec,
	input  wire logic [7:0] array_rdata,
	output logic      [7:0] flash_rdata,
	output logic            flash_read_undefined,
	output logic      [7:0] erase_enable,
	output logic            prog_active,
	output logic            erase_active,
	output logic            pverify_active,
	output logic            everify_active,
	output logic            prog_setup,
	output logic            erase_setup,
	output logic            flash_error_flag
);

	fpep_req_t   req;
	fpep_state_t state_q;
	fpep_state_t state_d;
	logic [7:0]  ctrl1_q;
	logic [7:0]  ctrl2_q;
	logic [7:0]  blksel_q;
	logic        flash_error_flag_q;
	logic        hw_prot;
	logic        pulse_on;
	logic        err_event;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// one bit of a register by field position, used for both control registers
	function automatic logic fld(input logic [7:0] r, input int pos);
		fld = r[pos];
	endfunction

	// pin low or standby forces protected; registers cleared below
	assign hw_prot = !flash_write_enable_pin || standby;

	// a pulse only runs with swe set and no hardware or error protection
	assign pulse_on = !hw_prot && fld(ctrl1_q, FPEP_C1_SWE) && !flash_error_flag_q
		&& (fld(ctrl1_q, FPEP_C1_PROG) || fld(ctrl1_q, FPEP_C1_ERASE));

	// malfunction detectors, only meaningful while a bit is really driving the array
	assign err_event = pulse_on && (flash_read || exception_start || sleep_exec);

	// control register one; pin low and standby clear it
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			ctrl1_q <= FPEP_CTRL_RST;
		else if (hw_prot)
			ctrl1_q <= FPEP_CTRL_RST;
		else if (req.wr && req.addr == FPEP_OFS_CTRL1)
			ctrl1_q <= req.wdata; // writable even in error state
	end

	// control register two, error bit kept apart
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			ctrl2_q <= FPEP_CTRL_RST;
		else if (hw_prot)
			ctrl2_q <= FPEP_CTRL_RST;
		else if (req.wr && req.addr == FPEP_OFS_CTRL2)
			ctrl2_q <= {1'b0, req.wdata[6:0]};
	end

	// block select register
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			blksel_q <= FPEP_BLK_RST;
		else if (hw_prot)
			blksel_q <= FPEP_BLK_RST;
		else if (req.wr && req.addr == FPEP_OFS_BLKSEL)
			blksel_q <= req.wdata;
	end

	// sticky error flag: only reset clears, no write path, pin ignored
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			flash_error_flag_q <= 1'b0;
		else if (err_event)
			flash_error_flag_q <= 1'b1;
	end

	// state tracking for visibility
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			FPEP_ST_PROT:
			begin
				if (flash_error_flag_q)
					state_d = FPEP_ST_ERR;
				else if (!hw_prot && fld(ctrl1_q, FPEP_C1_SWE))
					state_d = FPEP_ST_OPEN;
			end
			// flag may rise in the very cycle protection lifts, so look at it here too
			FPEP_ST_OPEN:
			begin
				if (err_event || flash_error_flag_q)
					state_d = FPEP_ST_ERR;
				else if (hw_prot || !fld(ctrl1_q, FPEP_C1_SWE))
					state_d = FPEP_ST_PROT;
			end
			FPEP_ST_ERR:
			begin
				if (standby)
					state_d = FPEP_ST_HOLD;
			end
			FPEP_ST_HOLD:
			begin
				if (!standby)
					state_d = FPEP_ST_ERR;
			end
			default:      state_d = FPEP_ST_PROT;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			state_q <= FPEP_ST_PROT;
		else
			state_q <= state_d;
	end

	// array controls; error aborts pulses but leaves verify usable
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			prog_active    <= 1'b0;
			erase_active   <= 1'b0;
			pverify_active <= 1'b0;
			everify_active <= 1'b0;
			prog_setup     <= 1'b0;
			erase_setup    <= 1'b0;
			erase_enable   <= 8'h00;
		end
		else
		begin
			prog_active  <= pulse_on && !err_event && fld(ctrl1_q, FPEP_C1_PROG)
				&& blksel_q != 8'h00;
			erase_active <= pulse_on && !err_event && fld(ctrl1_q, FPEP_C1_ERASE)
				&& blksel_q != 8'h00;
			pverify_active <= !hw_prot && fld(ctrl1_q, FPEP_C1_SWE) && fld(ctrl1_q, FPEP_C1_PV);
			everify_active <= !hw_prot && fld(ctrl1_q, FPEP_C1_SWE) && fld(ctrl1_q, FPEP_C1_EV);
			prog_setup   <= !hw_prot && fld(ctrl1_q, FPEP_C1_SWE) && fld(ctrl2_q, FPEP_C2_PSU);
			erase_setup  <= !hw_prot && fld(ctrl1_q, FPEP_C1_SWE) && fld(ctrl2_q, FPEP_C2_ESU);
			erase_enable <= (pulse_on && !err_event) ? blksel_q : 8'h00;
		end
	end

	// read data path; undefined marked, data forced while bits set
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			flash_rdata          <= 8'h00;
			flash_read_undefined <= 1'b0;
		end
		else
		begin
			flash_read_undefined <= fld(ctrl1_q, FPEP_C1_PROG) || fld(ctrl1_q, FPEP_C1_ERASE);
			flash_rdata <= (fld(ctrl1_q, FPEP_C1_PROG) || fld(ctrl1_q, FPEP_C1_ERASE)) ? 8'hff : array_rdata;
		end
	end

	// register read port, data one cycle after strobe
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (req.rd)
			unique case (req.addr)
				FPEP_OFS_CTRL1:  reg_rdata <= ctrl1_q;
				FPEP_OFS_CTRL2:  reg_rdata <= {flash_error_flag_q, ctrl2_q[6:0]};
				FPEP_OFS_BLKSEL: reg_rdata <= blksel_q;
				default:         reg_rdata <= 8'h00;
			endcase
		else
			reg_rdata <= 8'h00;
	end

	assign flash_error_flag = flash_error_flag_q;

	a_err_sticky: assert property (@(posedge mclk) disable iff (!rstn)
		flash_error_flag_q |=> flash_error_flag_q) else $error("error flag dropped without reset");
	a_err_set: assert property (@(posedge mclk) disable iff (!rstn)
		(pulse_on && flash_read) |=> flash_error_flag_q) else $error("read during pulse not flagged");
	a_exc_set: assert property (@(posedge mclk) disable iff (!rstn)
		(pulse_on && exception_start) |=> flash_error_flag_q && !prog_active && !erase_active) else $error("exception not flagged");
	a_sleep_set: assert property (@(posedge mclk) disable iff (!rstn)
		(pulse_on && sleep_exec) |=> flash_error_flag_q) else $error("sleep not flagged");
	a_pin_clears: assert property (@(posedge mclk) disable iff (!rstn)
		!flash_write_enable_pin |=> ctrl1_q == 8'h00 && blksel_q == 8'h00) else $error("pin low did not clear");
	a_hw_block: assert property (@(posedge mclk) disable iff (!rstn)
		hw_prot |=> !prog_active && !erase_active && !pverify_active && erase_enable == 8'h00)
		else $error("operation under hardware protection");
	a_swe_block: assert property (@(posedge mclk) disable iff (!rstn)
		!fld(ctrl1_q, FPEP_C1_SWE) |=> !prog_active && !erase_active && !everify_active)
		else $error("operation with swe clear");
	a_err_noprog: assert property (@(posedge mclk) disable iff (!rstn)
		flash_error_flag_q |=> !prog_active && !erase_active) else $error("pulse restarted in error state");
	a_zero_sel: assert property (@(posedge mclk) disable iff (!rstn)
		blksel_q == 8'h00 |=> !erase_active && !prog_active) else $error("pulse with no block selected");
	a_undef_rd: assert property (@(posedge mclk) disable iff (!rstn)
		fld(ctrl1_q, FPEP_C1_ERASE) |=> flash_read_undefined) else $error("read not marked undefined");

	// standby clears control one, control two and block select; the error flag stays set
	a_standby_clr: assert property (@(posedge mclk) disable iff (!rstn)
		standby |=> ctrl1_q == FPEP_CTRL_RST && ctrl2_q == FPEP_CTRL_RST && blksel_q == FPEP_BLK_RST)
		else $error("standby did not clear registers");

	// pin low clears control two as well
	a_pin_ctrl2: assert property (@(posedge mclk) disable iff (!rstn)
		!flash_write_enable_pin |=> ctrl2_q == FPEP_CTRL_RST)
		else $error("pin low did not clear control two");

	// no program pulse without its mode bit
	a_prog_bit: assert property (@(posedge mclk) disable iff (!rstn)
		!fld(ctrl1_q, FPEP_C1_PROG) |=> !prog_active)
		else $error("program pulse without mode bit");

	// no erase pulse without its mode bit
	a_erase_bit: assert property (@(posedge mclk) disable iff (!rstn)
		!fld(ctrl1_q, FPEP_C1_ERASE) |=> !erase_active)
		else $error("erase pulse without mode bit");

	// block enables all low while no pulse may run
	a_sel_idle: assert property (@(posedge mclk) disable iff (!rstn)
		!pulse_on |=> erase_enable == FPEP_BLK_RST)
		else $error("block enabled with no pulse");

	// only selected blocks see the pulse
	a_sel_follow: assert property (@(posedge mclk) disable iff (!rstn)
		(pulse_on && !err_event) |=> erase_enable == $past(blksel_q))
		else $error("block enables differ from selection");

	// flag only rises on a detected malfunction
	a_flag_cause: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(flash_error_flag_q) |-> $past(err_event))
		else $error("error flag rose without cause");

	// program verify still reachable in error state
	a_pv_err: assert property (@(posedge mclk) disable iff (!rstn)
		(flash_error_flag_q && !hw_prot && fld(ctrl1_q, FPEP_C1_SWE) && fld(ctrl1_q, FPEP_C1_PV)) |=> pverify_active)
		else $error("program verify refused in error state");

	// erase verify still reachable in error state
	a_ev_err: assert property (@(posedge mclk) disable iff (!rstn)
		(flash_error_flag_q && !hw_prot && fld(ctrl1_q, FPEP_C1_SWE) && fld(ctrl1_q, FPEP_C1_EV)) |=> everify_active)
		else $error("erase verify refused in error state");

	// registers stay writable in error state
	a_err_wr: assert property (@(posedge mclk) disable iff (!rstn)
		(flash_error_flag_q && !hw_prot && req.wr && req.addr == FPEP_OFS_BLKSEL) |=> blksel_q == $past(req.wdata))
		else $error("block select write lost in error state");

	// tracker must follow the flag into error protection
	a_err_state: assert property (@(posedge mclk) disable iff (!rstn)
		flash_error_flag_q |=> (state_q == FPEP_ST_ERR || state_q == FPEP_ST_HOLD))
		else $error("state tracker left error protection");

	// standby inside error protection still clears registers
	a_stby_err: assert property (@(posedge mclk) disable iff (!rstn)
		(flash_error_flag_q && standby) |=> ctrl1_q == FPEP_CTRL_RST && blksel_q == FPEP_BLK_RST)
		else $error("standby in error state kept registers");

	// neither pin nor a write may clear the flag
	a_flag_keep: assert property (@(posedge mclk) disable iff (!rstn)
		(flash_error_flag_q && (!flash_write_enable_pin || req.wr)) |=> flash_error_flag_q)
		else $error("error flag cleared by pin or write");

	// software has no way to set the flag
	a_flag_ro: assert property (@(posedge mclk) disable iff (!rstn)
		(!flash_error_flag_q && !err_event) |=> !flash_error_flag_q)
		else $error("error flag set without malfunction");

	// exception start takes the block enables away at once
	a_exc_abort: assert property (@(posedge mclk) disable iff (!rstn)
		(pulse_on && exception_start) |=> erase_enable == FPEP_BLK_RST)
		else $error("exception did not abort block enables");

	// setup and verify lines are held off under hardware protection
	a_hw_setup: assert property (@(posedge mclk) disable iff (!rstn)
		hw_prot |=> !prog_setup && !erase_setup && !everify_active)
		else $error("setup or verify under hardware protection");

	// program bit set forces undefined read data
	a_undef_prog: assert property (@(posedge mclk) disable iff (!rstn)
		fld(ctrl1_q, FPEP_C1_PROG) |=> flash_read_undefined && flash_rdata == 8'hff)
		else $error("read during program not undefined");

	// clean reads pass array data one cycle later
	a_clean_rd: assert property (@(posedge mclk) disable iff (!rstn)
		!(fld(ctrl1_q, FPEP_C1_PROG) || fld(ctrl1_q, FPEP_C1_ERASE))
		|=> flash_rdata == $past(array_rdata) && !flash_read_undefined) else $error("array data not passed");

	// sleep during a pulse aborts it
	a_sleep_abort: assert property (@(posedge mclk) disable iff (!rstn)
		(pulse_on && sleep_exec) |=> !prog_active && !erase_active)
		else $error("sleep did not abort pulse");

endmodule
`default_nettype wire

// *** dv/fpep_array_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fpep_array_model
(
	input  wire logic       mclk,
	input  wire logic       flash_read,
	input  wire logic [7:0] fill,
	output logic      [7:0] array_rdata
);
	logic [7:0] last_q = 8'h00;
	// idle bus shows the inverted last byte, so stale data never passes for a match
	always_ff @(posedge mclk)
	begin
		if (flash_read)
			last_q <= fill;
	end
	assign array_rdata = flash_read ? fill : ~last_q;
endmodule
`default_nettype wire

// *** dv/flash_program_erase_protection_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_protection_bench;
	import fpep_pkg::*;
	logic        mclk, rstn, reg_wr, reg_rd, pin, standby, flash_read, exc, slp, rd_seen;
	logic        pact, eact, pvact, evact, flag, undef;
	logic [1:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, array_rdata, flash_rdata, erase_enable, fill;
	logic [31:0] lfsr_q = 32'hb196_e31c;
	logic [7:0]  exp_q[$];
	int          mismatches = 0;
	int          samples_checked = 0;

	fpep_protect dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_write_enable_pin(pin), .standby(standby),
		.flash_read(flash_read), .exception_start(exc), .sleep_exec(slp), .array_rdata(array_rdata),
		.flash_rdata(flash_rdata), .flash_read_undefined(undef), .erase_enable(erase_enable),
		.prog_active(pact), .erase_active(eact), .pverify_active(pvact), .everify_active(evact),
		.prog_setup(), .erase_setup(), .flash_error_flag(flag));
	fpep_array_model array (.mclk(mclk), .flash_read(flash_read), .fill(fill), .array_rdata(array_rdata));

	// clock, 50 ns period
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		print_verdict();
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// expected read data is queued; the watcher below takes it off
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// one-cycle fault pulse: 0 array read, 1 exception, 2 sleep
	task automatic pulse(input int k);
		@(posedge mclk);
		flash_read <= (k == 0);
		exc <= (k == 1);
		slp <= (k == 2);
		@(posedge mclk);
		{flash_read, exc, slp} <= 3'b000;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge mclk) rd_seen <= reg_rd;
	always @(negedge mclk)
		if (rd_seen && exp_q.size() > 0)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);

	initial
	begin
		{rstn, reg_wr, reg_rd, standby, flash_read, exc, slp} = '0;
		{reg_addr, reg_wdata, fill} = '0;
		pin = 1'b1;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		rd(FPEP_OFS_CTRL1, FPEP_CTRL_RST);
		rd(FPEP_OFS_CTRL2, FPEP_CTRL_RST);
		rd(FPEP_OFS_BLKSEL, FPEP_BLK_RST);
		rd(2'h3, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			lfsr_q = lfsr_next(lfsr_q);
			@(posedge mclk);
			fill <= lfsr_q[7:0];
			flash_read <= 1'b1;
			@(posedge mclk);
			flash_read <= 1'b0;
			#1 chk("flash_rdata", lfsr_q[7:0], flash_rdata);
		end
		wr(FPEP_OFS_CTRL1, 8'h01);
		settle(2);
		chk("prog_active", 8'h00, {7'h0, pact});
		wr(FPEP_OFS_CTRL1, 8'h41);
		settle(2);
		chk("prog_active", 8'h00, {7'h0, pact});
		wr(FPEP_OFS_BLKSEL, 8'h01);
		wr(FPEP_OFS_CTRL2, 8'h02);
		wr(FPEP_OFS_CTRL1, 8'h42);
		settle(2);
		chk("erase_active", 8'h01, {7'h0, eact});
		chk("erase_enable", 8'h01, erase_enable);
		wr(FPEP_OFS_BLKSEL, 8'h00);
		settle(2);
		chk("erase_active", 8'h00, {7'h0, eact});
		wr(FPEP_OFS_BLKSEL, 8'h01);
		settle(2);
		@(posedge mclk) pin <= 1'b0;
		settle(2);
		chk("erase_active", 8'h00, {7'h0, eact});
		rd(FPEP_OFS_CTRL1, 8'h00);
		rd(FPEP_OFS_BLKSEL, 8'h00);
		@(posedge mclk) pin <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			@(posedge mclk) rstn <= 1'b0;
			settle(FPEP_RST_HOLD_CYC);
			rstn <= 1'b1;
			wr(FPEP_OFS_BLKSEL, 8'h01);
			wr(FPEP_OFS_CTRL2, 8'h01);
			wr(FPEP_OFS_CTRL1, 8'h41);
			settle(2);
			chk("prog_active", 8'h01, {7'h0, pact});
			chk("read_undefined", 8'h01, {7'h0, undef});
			pulse(k);
			chk("error_flag", 8'h01, {7'h0, flag});
			chk("prog_active", 8'h00, {7'h0, pact});
			chk("flash_rdata", 8'hff, flash_rdata);
		end
		rd(FPEP_OFS_CTRL2, 8'h81);
		wr(FPEP_OFS_CTRL1, 8'h41);
		settle(2);
		chk("prog_active", 8'h00, {7'h0, pact});
		wr(FPEP_OFS_CTRL1, 8'h44);
		settle(2);
		chk("pverify_active", 8'h01, {7'h0, pvact});
		wr(FPEP_OFS_CTRL1, 8'h48);
		settle(2);
		chk("everify_active", 8'h01, {7'h0, evact});
		wr(FPEP_OFS_CTRL2, 8'h00);
		wr(FPEP_OFS_BLKSEL, 8'h03);
		rd(FPEP_OFS_CTRL2, 8'h80);
		rd(FPEP_OFS_BLKSEL, 8'h03);
		@(posedge mclk) standby <= 1'b1;
		settle(2);
		rd(FPEP_OFS_BLKSEL, 8'h00);
		rd(FPEP_OFS_CTRL1, 8'h00);
		@(posedge mclk) standby <= 1'b0;
		@(posedge mclk) pin <= 1'b0;
		rd(FPEP_OFS_CTRL2, 8'h80);
		@(posedge mclk) pin <= 1'b1;
		@(posedge mclk) rstn <= 1'b0;
		settle(FPEP_RST_HOLD_CYC);
		rstn <= 1'b1;
		rd(FPEP_OFS_CTRL2, 8'h00);
		settle(3);
		print_verdict();
	end
endmodule
`default_nettype wire
